/* hss_source_select.sv */
`timescale 1ns/1ps
module hss_source_select
    import hss_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic regWrite,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // mode events
    input wire logic softReset,
    input wire logic restartEnter,
    // fault flags
    input wire logic supplyOver,
    input wire logic supplyUnder,
    input wire logic [3:0] switchOverCurrent,
    input wire logic [3:0] switchOverTemp,
    // drive sources
    input wire logic timerAWave,
    input wire logic timerBWave,
    input wire logic dutyAWave,
    input wire logic dutyBWave,
    input wire logic failOutTwo,
    input wire logic failOutThree,
    // multipurpose pin inputs
    input wire logic [1:0] mpPinIn,
    // outputs
    output logic [3:0] switchOn,
    output logic [1:0] mpLowSideOn,
    output logic [1:0] mpHighSideOn,
    output logic [1:0] mpWakeEvent,
    output logic [1:0] failDutySelect
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rstSync1_q, rstSync2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    wire logic rstInt_n = rstSync2_q;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] sdCtrl_q, srcLow_q, srcHigh_q, mpCfg_q;
    logic [7:0] srcLow_d, srcHigh_d;
    logic [11:0] saved_q;
    logic supplyFault_q;

    wire logic wrSd = regWrite && (regAddr == SD_CTRL_OFFSET);
    wire logic wrLow = regWrite && (regAddr == SRC_LOW_OFFSET);
    wire logic wrHigh = regWrite && (regAddr == SRC_HIGH_OFFSET);
    wire logic wrMp = regWrite && (regAddr == MP_CFG_OFFSET);

    wire logic ovShut = supplyOver && !sdCtrl_q[OV_DIS_BIT];
    wire logic uvShut = supplyUnder && !sdCtrl_q[UV_DIS_BIT];
    wire logic supplyFault = ovShut || uvShut;
    wire logic faultEnd = supplyFault_q && !supplyFault;
    wire logic faultStart = supplyFault && !supplyFault_q;
    wire logic [3:0] swKill = switchOverCurrent | switchOverTemp;

    // per-switch fields, with fault clearing and recovery
    always_comb begin
        srcLow_d = wrLow ? (regWrData & SRC_MASK) : srcLow_q;
        srcHigh_d = wrHigh ? (regWrData & SRC_MASK) : srcHigh_q;
        if (faultEnd && sdCtrl_q[REC_EN_BIT]) begin
            srcLow_d = {1'b0, saved_q[5:3], 1'b0, saved_q[2:0]};
            srcHigh_d = {1'b0, saved_q[11:9], 1'b0, saved_q[8:6]};
        end
        // without recovery nothing comes back, so the fields go to off on entry
        if (faultStart && !sdCtrl_q[REC_EN_BIT]) begin
            srcLow_d = REG_RESET;
            srcHigh_d = REG_RESET;
        end
        // a fault on one switch must win over restore and writes
        if (swKill[0]) srcLow_d[2:0] = SRC_OFF;
        if (swKill[1]) srcLow_d[6:4] = SRC_OFF;
        if (swKill[2]) srcHigh_d[2:0] = SRC_OFF;
        if (swKill[3]) srcHigh_d[6:4] = SRC_OFF;
        if (restartEnter) begin
            srcLow_d = REG_RESET;
            srcHigh_d = REG_RESET;
        end
    end

    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            sdCtrl_q <= REG_RESET;
            srcLow_q <= REG_RESET;
            srcHigh_q <= REG_RESET;
            mpCfg_q <= REG_RESET;
        end else if (softReset) begin
            sdCtrl_q <= REG_RESET;
            srcLow_q <= REG_RESET;
            srcHigh_q <= REG_RESET;
            mpCfg_q <= REG_RESET;
        end else begin
            if (restartEnter) sdCtrl_q <= sdCtrl_q & SD_CTRL_MASK;
            else if (wrSd) sdCtrl_q <= regWrData & SD_CTRL_MASK;
            srcLow_q <= srcLow_d;
            srcHigh_q <= srcHigh_d;
            if (wrMp) mpCfg_q <= regWrData;
        end
    end

    // snapshot taken on fault entry; switches are forced off meanwhile
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            saved_q <= 12'h000;
            supplyFault_q <= 1'b0;
        end else begin
            supplyFault_q <= supplyFault;
            if (supplyFault && !supplyFault_q) begin
                saved_q <= {srcHigh_q[6:4], srcHigh_q[2:0], srcLow_q[6:4], srcLow_q[2:0]};
            end else if (faultEnd && !sdCtrl_q[REC_EN_BIT]) begin
                saved_q <= 12'h000;
            end
        end
    end


    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        unique case (regAddr)
            SD_CTRL_OFFSET: regRdData = sdCtrl_q;
            SRC_LOW_OFFSET: regRdData = srcLow_q;
            SRC_HIGH_OFFSET: regRdData = srcHigh_q;
            MP_CFG_OFFSET: regRdData = mpCfg_q;
            default: regRdData = 8'h00;
        endcase
    end

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    logic [3:0] swSel;
    logic [11:0] fields;
    assign fields = {srcHigh_q[6:4], srcHigh_q[2:0], srcLow_q[6:4], srcLow_q[2:0]};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            unique case (fields[3*i +: 3])
                SRC_ON: swSel[i] = 1'b1;
                SRC_TIMER_A: swSel[i] = timerAWave;
                SRC_TIMER_B: swSel[i] = timerBWave;
                SRC_DUTY_A: swSel[i] = dutyAWave;
                SRC_DUTY_B: swSel[i] = dutyBWave;
                default: swSel[i] = 1'b0;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) switchOn <= 4'h0;
        else switchOn <= supplyFault ? 4'h0 : (swSel & ~swKill);
    end

    // ----------------------------------------
    // multipurpose pins
    // ----------------------------------------
    wire logic [2:0] mpCode [2];
    assign mpCode[0] = mpCfg_q[2:0];
    assign mpCode[1] = mpCfg_q[MP_TWO_LSB +: 3];
    wire logic [1:0] failSrc = {failOutThree, failOutTwo};
    assign failDutySelect = mpCfg_q[FO_DUTY_LSB +: 2];

    logic [2:0] pinSync_q [2];
    logic [10:0] filtCnt_q [2];
    logic [1:0] pinLevel_q;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gMp
            wire logic isFail = !mpCode[g][2];
            wire logic isWake = mpCode[g] == MP_WAKE;
            wire logic stable = pinSync_q[g][1] == pinSync_q[g][2];
            always_ff @(posedge clk or negedge rstInt_n) begin
                if (!rstInt_n) begin
                    mpLowSideOn[g] <= 1'b0;
                    mpHighSideOn[g] <= 1'b0;
                end else begin
                    mpLowSideOn[g] <= mpCode[g] == MP_LOW_SIDE;
                    mpHighSideOn[g] <= (mpCode[g] == MP_HIGH_SIDE) || (isFail && failSrc[g]);
                end
            end
            // static wake filter: level must hold for the filter time
            always_ff @(posedge clk or negedge rstInt_n) begin
                if (!rstInt_n) begin
                    pinSync_q[g] <= 3'h0;
                    filtCnt_q[g] <= 11'h000;
                    pinLevel_q[g] <= 1'b0;
                    mpWakeEvent[g] <= 1'b0;
                end else begin
                    pinSync_q[g] <= {pinSync_q[g][1:0], mpPinIn[g]};
                    mpWakeEvent[g] <= 1'b0;
                    if (!isWake || !stable || pinSync_q[g][2] == pinLevel_q[g]) begin
                        filtCnt_q[g] <= 11'h000;
                    end else if (filtCnt_q[g] == 11'(WAKE_FILTER_CYC - 1)) begin
                        filtCnt_q[g] <= 11'h000;
                        pinLevel_q[g] <= pinSync_q[g][2];
                        mpWakeEvent[g] <= 1'b1;
                    end else begin
                        filtCnt_q[g] <= filtCnt_q[g] + 11'h001;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_OV_SHUT: assert property (@(posedge clk) disable iff (!rstInt_n)
        supplyOver && !sdCtrl_q[OV_DIS_BIT] |=> switchOn == 4'h0)
        else $error("overvoltage did not turn switches off");
    AST_UV_SHUT: assert property (@(posedge clk) disable iff (!rstInt_n)
        supplyUnder && !sdCtrl_q[UV_DIS_BIT] |=> switchOn == 4'h0)
        else $error("undervoltage did not turn switches off");
    AST_KILL: assert property (@(posedge clk) disable iff (!rstInt_n)
        swKill[0] && !softReset |=> srcLow_q[2:0] == SRC_OFF)
        else $error("fault did not clear source field");
    AST_RSV_ZERO: assert property (@(posedge clk) disable iff (!rstInt_n)
        (sdCtrl_q & ~SD_CTRL_MASK) == 8'h00 && (srcLow_q & ~SRC_MASK) == 8'h00)
        else $error("reserved bit set");
    AST_RESTART_SD: assert property (@(posedge clk) disable iff (!rstInt_n)
        restartEnter && !softReset |=> sdCtrl_q == ($past(sdCtrl_q) & SD_CTRL_MASK))
        else $error("restart changed shutdown bits");
    AST_RESTART_SRC: assert property (@(posedge clk) disable iff (!rstInt_n)
        restartEnter |=> srcLow_q == 8'h00 && srcHigh_q == 8'h00)
        else $error("restart left switches set");
    AST_RESTART_MP: assert property (@(posedge clk) disable iff (!rstInt_n)
        restartEnter && !softReset && !wrMp |=> $stable(mpCfg_q))
        else $error("restart changed pin config");
    AST_RSV_SRC: assert property (@(posedge clk) disable iff (!rstInt_n)
        srcLow_q[2:1] == 2'b11 |=> !switchOn[0])
        else $error("reserved code drove a switch");
    AST_NO_REC: assert property (@(posedge clk) disable iff (!rstInt_n)
        faultStart && !sdCtrl_q[REC_EN_BIT] |=> srcLow_q == 8'h00 && srcHigh_q == 8'h00)
        else $error("fault without recovery left switches set");
    AST_KILL_NEXT: assert property (@(posedge clk) disable iff (!rstInt_n)
        (|swKill) |=> (switchOn & $past(swKill)) == 4'h0)
        else $error("faulted switch still driven one cycle later");
endmodule // hss_source_select

/* hss_pkg.sv */
package hss_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [6:0] SD_CTRL_OFFSET = 7'h10;
    localparam logic [6:0] SRC_LOW_OFFSET = 7'h14;
    localparam logic [6:0] SRC_HIGH_OFFSET = 7'h15;
    localparam logic [6:0] MP_CFG_OFFSET = 7'h17;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int OV_DIS_BIT = 6;
    localparam int UV_DIS_BIT = 5;
    localparam int REC_EN_BIT = 4;
    localparam logic [7:0] SD_CTRL_MASK = 8'h70;
    localparam logic [7:0] SRC_MASK = 8'h77;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FO_DUTY_LSB = 6;
    localparam int MP_TWO_LSB = 3;
    // ----------------------------------------
    // switch source codes
    // ----------------------------------------
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_ON = 3'h1;
    localparam logic [2:0] SRC_TIMER_A = 3'h2;
    localparam logic [2:0] SRC_TIMER_B = 3'h3;
    localparam logic [2:0] SRC_DUTY_A = 3'h4;
    localparam logic [2:0] SRC_DUTY_B = 3'h5;
    // ----------------------------------------
    // multipurpose pin codes
    // ----------------------------------------
    localparam logic [2:0] MP_OFF = 3'h4;
    localparam logic [2:0] MP_WAKE = 3'h5;
    localparam logic [2:0] MP_LOW_SIDE = 3'h6;
    localparam logic [2:0] MP_HIGH_SIDE = 3'h7;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WAKE_FILTER_US = 16;
    localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CLK_MHZ;
endpackage

/* hss_tb.sv */
`timescale 1ns/1ps
module tb import hss_pkg::*; ;
    typedef struct {int sel; logic [7:0] exp;} hss_note_s;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk, rstN, regWrite, softReset, restartEnter, supplyOver, supplyUnder;
    logic timerAWave, timerBWave, dutyAWave, dutyBWave, failOutTwo, failOutThree;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, seen, expLo;
    logic [3:0] switchOverCurrent, switchOverTemp, switchOn;
    logic [1:0] mpPinIn, mpLowSideOn, mpHighSideOn, mpWakeEvent, failDutySelect, fo;
    logic [31:0] rng;
    logic wakeOk;
    logic [1:0] pa, pb;
    logic [6:0] addrs [5] = '{7'h10, 7'h14, 7'h15, 7'h17, 7'h11};
    int nMismatch, nTests, cnt;
    hss_note_s notes[$];
    hss_note_s n;
    event resultReady;
    string names[5] = '{"regRdData", "switchOn", "mpDrive", "failDutySelect", "wakeTimely"};

    hss_source_select dut (.clk(clk), .rst_n(rstN), .regWrite(regWrite), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .softReset(softReset),
        .restartEnter(restartEnter), .supplyOver(supplyOver), .supplyUnder(supplyUnder),
        .switchOverCurrent(switchOverCurrent), .switchOverTemp(switchOverTemp),
        .timerAWave(timerAWave), .timerBWave(timerBWave), .dutyAWave(dutyAWave),
        .dutyBWave(dutyBWave), .failOutTwo(failOutTwo), .failOutThree(failOutThree),
        .mpPinIn(mpPinIn), .switchOn(switchOn), .mpLowSideOn(mpLowSideOn),
        .mpHighSideOn(mpHighSideOn), .mpWakeEvent(mpWakeEvent), .failDutySelect(failDutySelect));

    always #5 clk = ~clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // reserved codes fall to off so the pin never follows an undefined source
    function automatic logic srcExp(input logic [2:0] c);
        case (c)
            3'h1: return 1'b1;
            3'h2: return timerAWave;
            3'h3: return timerBWave;
            3'h4: return dutyAWave;
            3'h5: return dutyBWave;
            default: return 1'b0;
        endcase
    endfunction
    // returns {high, low}; codes 0..3 route the fail output on the high-side drive
    function automatic logic [1:0] mpExp(input logic [2:0] c, input logic f);
        if (c < 3'h4) return {f, 1'b0};
        if (c == 3'h6) return 2'b01;
        if (c == 3'h7) return 2'b10;
        return 2'b00;
    endfunction
    task automatic note(input int sel, input logic [7:0] e);
        notes.push_back('{sel, e});
        ->resultReady;
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        #1;
        note(0, e);
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // output monitor
    // ----------------------------------------
    initial forever begin
        @(resultReady);
        // several notes can land in one time step, so drain them all
        while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.sel)
                0: seen = regRdData;
                1: seen = {4'h0, switchOn};
                2: seen = {4'h0, mpHighSideOn, mpLowSideOn};
                3: seen = {6'h00, failDutySelect};
                default: seen = {7'h00, wakeOk};
            endcase
            nTests++;
            if (seen !== n.exp) begin
                nMismatch++;
                $display("wrong value %s expected %h seen %h", names[n.sel], n.exp, seen);
            end
        end
    end
    initial begin
        #900000;
        nMismatch++;
        finishTest();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clk, regWrite, softReset, restartEnter, supplyOver, supplyUnder} = '0;
        {timerAWave, timerBWave, dutyAWave, dutyBWave, failOutTwo, failOutThree} = '0;
        {regAddr, regWrData, switchOverCurrent, switchOverTemp, mpPinIn} = '0;
        rstN = 1'b0;
        rng = 32'h7754;
        wakeOk = 1'b0;
        idle(12);
        rstN = 1'b1;
        idle(3);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        wr(7'h10, 8'hFF);
        rd(7'h10, 8'h70);
        wr(7'h14, 8'hFF);
        rd(7'h14, 8'h77);
        wr(7'h15, 8'hFF);
        rd(7'h15, 8'h77);
        wr(7'h11, 8'hFF);
        rd(7'h11, 8'h00);
        idle(3);
        note(1, 8'h00);
        wr(7'h10, 8'h00);
        for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            {timerAWave, timerBWave, dutyAWave, dutyBWave} = rng[3:0];
            wr(7'h14, {1'b0, c[2:0], 1'b0, c[2:0]});
            wr(7'h15, {1'b0, c[2:0], 1'b0, c[2:0]});
            idle(3);
            note(1, {4'h0, {4{srcExp(c[2:0])}}});
        end
        for (int j = 0; j < 8; j++) begin
            wr(7'h14, 8'h11);
            wr(7'h15, 8'h11);
            @(negedge clk);
            if (j < 4) switchOverCurrent[j % 4] = 1'b1;
            else switchOverTemp[j % 4] = 1'b1;
            @(negedge clk);
            note(1, {4'h0, ~(4'h1 << (j % 4))});
            {switchOverCurrent, switchOverTemp} = '0;
            idle(3);
            note(1, {4'h0, ~(4'h1 << (j % 4))});
            expLo = (j % 4 == 0) ? 8'h10 : ((j % 4 == 1) ? 8'h01 : 8'h11);
            rd(7'h14, expLo);
            expLo = (j % 4 == 2) ? 8'h10 : ((j % 4 == 3) ? 8'h01 : 8'h11);
            rd(7'h15, expLo);
        end
        for (int k = 0; k < 2; k++) begin
            for (int d = 0; d < 2; d++) begin
                wr(7'h14, 8'h11);
                wr(7'h15, 8'h11);
                wr(7'h10, 8'h10 | (d[7:0] << (k ? 5 : 6)));
                @(negedge clk);
                if (k == 0) supplyOver = 1'b1;
                else supplyUnder = 1'b1;
                @(negedge clk);
                note(1, d ? 8'h0F : 8'h00);
                idle(2);
                {supplyOver, supplyUnder} = '0;
                idle(3);
                note(1, 8'h0F);
            end
        end
        wr(7'h10, 8'h00);
        @(negedge clk);
        supplyUnder = 1'b1;
        @(negedge clk);
        note(1, 8'h00);
        idle(2);
        supplyUnder = 1'b0;
        idle(3);
        note(1, 8'h00);
        rd(7'h14, 8'h00);
        rd(7'h15, 8'h00);
        for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            fo = rng[1:0];
            {failOutTwo, failOutThree} = fo;
            wr(7'h17, {rng[3:2], c[2:0], c[2:0]});
            idle(3);
            pa = mpExp(c[2:0], fo[1]);
            pb = mpExp(c[2:0], fo[0]);
            note(2, {4'h0, pb[1], pa[1], pb[0], pa[0]});
            note(3, {6'h00, rng[3:2]});
        end
        wr(7'h17, 8'h25);
        idle(5);
        mpPinIn[0] = 1'b1;
        cnt = 0;
        while (mpWakeEvent[0] !== 1'b1 && cnt < 3000) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 3000) begin
            nMismatch++;
            finishTest();
        end
        wakeOk = (cnt >= WAKE_FILTER_CYC) && (cnt <= WAKE_FILTER_CYC + 10);
        note(4, 8'h01);
        wr(7'h10, 8'h70);
        wr(7'h14, 8'h11);
        wr(7'h15, 8'h23);
        wr(7'h17, 8'hAB);
        @(negedge clk);
        restartEnter = 1'b1;
        @(negedge clk);
        restartEnter = 1'b0;
        rd(7'h10, 8'h70);
        rd(7'h14, 8'h00);
        rd(7'h15, 8'h00);
        rd(7'h17, 8'hAB);
        idle(3);
        note(1, 8'h00);
        wr(7'h14, 8'h11);
        @(negedge clk);
        softReset = 1'b1;
        @(negedge clk);
        softReset = 1'b0;
        for (int i = 0; i < 4; i++) rd(addrs[i], 8'h00);
        idle(2);
        finishTest();
    end
endmodule // tb
